// ### inc/csc_pkg.sv
// shared constants for the codec status command link and its two ends
package csc_pkg;
    // byte framing
    localparam logic [7:0] CSC_IDLE_BYTE = 8'hff;
    // identification byte, value is arbitrary
    localparam logic [7:0] CSC_ID_DEFAULT = 8'h5a;
    localparam logic [7:0] CSC_CFG_RESET = 8'h00;

    // command byte fields
    localparam int CSC_CMD_CH_HI = 7;
    localparam int CSC_CMD_CH_LO = 6;
    localparam int CSC_CMD_RW_BIT = 5;
    localparam int CSC_CMD_KIND_HI = 4;
    localparam int CSC_CMD_KIND_LO = 3;
    localparam int CSC_CMD_LEN_HI = 2;
    localparam int CSC_CMD_LEN_LO = 0;
    localparam int CSC_CMD_COP_SHORT_BIT = 3;
    localparam logic [1:0] CSC_KIND_STATUS = 2'h2;
    localparam logic [1:0] CSC_KIND_EXT = 2'h3;
    localparam int CSC_KIND_COEF_BIT = 4;
    localparam logic [2:0] CSC_LEN_MAX = 3'h5;
    localparam logic [2:0] CSC_COP_SHORT_LAST = 3'h3;
    localparam logic [2:0] CSC_COP_LONG_LAST = 3'h7;

    // configuration register indices
    localparam int CSC_NUM_CH = 4;
    localparam int CSC_NUM_CFG = 4;
    localparam logic [2:0] CSC_REG_FILTER = 3'h0;
    localparam logic [2:0] CSC_REG_TONE = 3'h1;
    localparam logic [2:0] CSC_REG_CUTOFF = 3'h2;
    localparam logic [2:0] CSC_REG_LOOP = 3'h3;

    // filter_enable_config
    localparam int CSC_FLT_EN_HI = 7;
    localparam int CSC_FLT_EN_LO = 2;
    localparam int CSC_ECHO_SET_HI = 1;
    localparam int CSC_ECHO_SET_LO = 0;
    // tone_law_power_config
    localparam int CSC_TONE2_ON_BIT = 7;
    localparam int CSC_TONE1_ON_BIT = 6;
    localparam int CSC_TONE2_CUSTOM_BIT = 5;
    localparam int CSC_TONE1_CUSTOM_BIT = 4;
    localparam int CSC_MU_LAW_BIT = 3;
    localparam int CSC_POWER_ON_BIT = 2;
    // cutoff_metering_config
    localparam int CSC_CUTOFF_HI = 7;
    localparam int CSC_CUTOFF_LO = 5;
    localparam int CSC_CLEAR_RAM_BIT = 3;
    localparam int CSC_METER_EN_BIT = 2;
    localparam int CSC_METER_RESULT_BIT = 1;
    localparam int CSC_VOICE_TONE_BIT = 0;
    // loopback_gain_config
    localparam int CSC_LOOP_HI = 7;
    localparam int CSC_LOOP_LO = 4;
    localparam int CSC_TX_BOOST_BIT = 3;
    localparam int CSC_RX_CUT_BIT = 2;
    localparam int CSC_TX_HP_OFF_BIT = 1;
    localparam int CSC_RX_HP_OFF_BIT = 0;

    localparam int CSC_METER_W = 16;

    // host register byte offsets
    localparam logic [7:0] CSC_OFF_CTRL = 8'h00;
    localparam logic [7:0] CSC_OFF_TXCMD = 8'h04;
    localparam logic [7:0] CSC_OFF_TXDATA = 8'h08;
    localparam logic [7:0] CSC_OFF_STATUS = 8'h0c;
    localparam logic [7:0] CSC_OFF_RXDATA = 8'h10;
    localparam int CSC_CTRL_FRAME_BIT = 0;
    localparam int CSC_STAT_BUSY_BIT = 0;
    localparam int CSC_STAT_FRAME_BIT = 1;
    localparam int CSC_STAT_REFUSED_BIT = 2;

    // link timing
    localparam int CSC_CLK_PERIOD_NS = 10;
    localparam int CSC_DCLK_HALF_NS = 50;
    localparam int CSC_DCLK_HALF_CYC =
        (CSC_DCLK_HALF_NS + CSC_CLK_PERIOD_NS - 1) / CSC_CLK_PERIOD_NS;
    localparam logic [3:0] CSC_HALF_LAST = 4'(CSC_DCLK_HALF_CYC - 1);
endpackage

// ### inc/csc_link_if.sv
// serial command link between controller and codec
`timescale 1ns/1ps
interface csc_link_if;
    logic cs_n;
    logic dclk;
    logic din;
    logic dout;
    modport device (input cs_n, input dclk, input din, output dout);
    modport host (output cs_n, output dclk, output din, input dout);
endinterface

// ### core/csc_device.sv
// codec end: status command decoder and per-channel configuration registers
`timescale 1ns/1ps
module csc_device
    import csc_pkg::*;
#(
    parameter logic [7:0] ID_CODE = CSC_ID_DEFAULT
) (
    input wire logic clock_in, // 100 MHz clock
    input wire logic rst_n_in, // synchronous reset, active low
    csc_link_if.device link, // serial command link
    input wire logic [3:0][CSC_METER_W-1:0] meter_sample_in, // signed samples to level metering
    input wire logic [3:0] meter_valid_in, // sample strobe per channel
    input wire logic [CSC_METER_W-1:0] meter_threshold_in, // metering threshold
    output logic [3:0][5:0] filter_en_out, // echo, imp, txresp, rxresp, txgain, rxgain
    output logic [3:0][1:0] echo_set_out, // echo coefficient set
    output logic [3:0][1:0] tone_on_out, // [1] tone 2, [0] tone 1 running
    output logic [3:0][1:0] tone_custom_out, // programmed frequency per tone
    output logic [3:0] mu_law_out, // 1 mu-law, 0 A-law
    output logic [3:0] power_on_out, // 1 operating, 0 standby
    output logic [3:0][2:0] cutoff_out, // path cut-off code
    output logic [3:0] clear_ram_out, // data RAM held at zero
    output logic [3:0] meter_en_out, // level metering active
    output logic [3:0] meter_result_out, // level above threshold
    output logic [3:0] voice_tone_out, // voice and tone summed
    output logic [3:0][3:0] loopback_out, // loopback mode code
    output logic [3:0] tx_boost_out, // transmit analog gain
    output logic [3:0] rx_cut_out, // receive analog attenuation
    output logic [3:0][1:0] hp_off_out // [1] tx, [0] rx highpass bypassed
);
    typedef enum logic [4:0] {
        ST_CMD = 5'b00001,
        ST_WR = 5'b00010,
        ST_RD_ID = 5'b00100,
        ST_RD_DATA = 5'b01000,
        ST_SKIP = 5'b10000
    } csc_dev_state_e;

    csc_dev_state_e state;
    logic dclk_q;
    logic [2:0] bit_cnt;
    logic [6:0] rx_shift;
    logic [7:0] tx_shift;
    logic dout;
    logic [1:0] ch;
    logic [2:0] idx;
    logic is_sop;
    logic [3:0][3:0][7:0] cfg;
    logic [3:0] meter_result;
    logic [2:0] rd_idx;
    logic [7:0] rd_val;

    wire dclk_rise = link.dclk & ~dclk_q;
    wire dclk_fall = ~link.dclk & dclk_q;
    wire [7:0] rx_byte = {rx_shift, link.din};
    wire byte_done = dclk_rise && !link.cs_n && (bit_cnt == 3'h7);
    wire cmd_read = rx_byte[CSC_CMD_RW_BIT];
    wire [1:0] cmd_kind = rx_byte[CSC_CMD_KIND_HI:CSC_CMD_KIND_LO];
    wire [2:0] cmd_len = rx_byte[CSC_CMD_LEN_HI:CSC_CMD_LEN_LO];

    assign link.dout = dout;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            dclk_q <= 1'b0;
        end else begin
            dclk_q <= link.dclk;
        end
    end

    // partial byte dropped
    // a byte cut short by deselect never reaches byte_done, so it is lost
    always_ff @(posedge clock_in) begin
        if (!rst_n_in || link.cs_n) begin
            bit_cnt <= 3'h0;
            rx_shift <= 7'h00;
        end else if (dclk_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            rx_shift <= rx_byte[6:0];
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in || link.cs_n) begin
            state <= ST_CMD;
            ch <= 2'h0;
            idx <= 3'h0;
            is_sop <= 1'b0;
        end else if (byte_done) begin
            case (state)
                ST_CMD: begin
                    ch <= rx_byte[CSC_CMD_CH_HI:CSC_CMD_CH_LO];
                    is_sop <= (cmd_kind == CSC_KIND_STATUS);
                    if (!rx_byte[CSC_KIND_COEF_BIT]) begin
                        idx <= rx_byte[CSC_CMD_COP_SHORT_BIT] ? CSC_COP_SHORT_LAST
                                                              : CSC_COP_LONG_LAST;
                    end else begin
                        idx <= cmd_len;
                    end
                    if (cmd_read) begin
                        state <= ST_RD_ID;
                    end else if (cmd_kind == CSC_KIND_STATUS) begin
                        state <= ST_WR;
                    end else begin
                        state <= ST_SKIP;
                    end
                end
                ST_RD_ID: begin
                    state <= ST_RD_DATA;
                end
                ST_WR, ST_RD_DATA, ST_SKIP: begin
                    if (idx == 3'h0) begin
                        state <= ST_CMD;
                    end else begin
                        idx <= idx - 3'h1;
                    end
                end
                default: begin
                    state <= ST_CMD;
                end
            endcase
        end
    end

    // registers above the four held here accept and drop their bytes
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            cfg <= {(CSC_NUM_CH * CSC_NUM_CFG) {CSC_CFG_RESET}};
        end else if (byte_done && state == ST_WR && idx < 3'(CSC_NUM_CFG)) begin
            cfg[ch][idx[1:0]] <= rx_byte;
        end
    end

    // the byte loaded at a byte end goes out during the next byte
    assign rd_idx = (state == ST_RD_ID) ? idx : idx - 3'h1;

    always_comb begin
        rd_val = 8'h00;
        if (is_sop && rd_idx < 3'(CSC_NUM_CFG)) begin
            rd_val = cfg[ch][rd_idx[1:0]];
            if (rd_idx == CSC_REG_CUTOFF) begin
                rd_val[CSC_METER_RESULT_BIT] = meter_result[ch];
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in || link.cs_n) begin
            tx_shift <= CSC_IDLE_BYTE;
            dout <= 1'b1;
        end else if (byte_done) begin
            case (state)
                ST_CMD: tx_shift <= cmd_read ? ID_CODE : CSC_IDLE_BYTE;
                ST_RD_ID: tx_shift <= rd_val;
                ST_RD_DATA: tx_shift <= (idx == 3'h0) ? CSC_IDLE_BYTE : rd_val;
                default: tx_shift <= CSC_IDLE_BYTE;
            endcase
        end else if (dclk_fall) begin
            dout <= tx_shift[7];
            tx_shift <= {tx_shift[6:0], 1'b1};
        end
    end

    genvar g;
    generate
        for (g = 0; g < CSC_NUM_CH; g++) begin : gen_ch
            logic [CSC_METER_W-1:0] mag;
            assign mag = meter_sample_in[g][CSC_METER_W-1] ? CSC_METER_W'(-meter_sample_in[g])
                                                           : meter_sample_in[g];
            always_ff @(posedge clock_in) begin
                if (!rst_n_in) begin
                    meter_result[g] <= 1'b0;
                end else if (cfg[g][CSC_REG_CUTOFF][CSC_METER_EN_BIT] && meter_valid_in[g]) begin
                    meter_result[g] <= (mag > meter_threshold_in);
                end
            end
            assign filter_en_out[g] = cfg[g][CSC_REG_FILTER][CSC_FLT_EN_HI:CSC_FLT_EN_LO];
            assign echo_set_out[g] = cfg[g][CSC_REG_FILTER][CSC_ECHO_SET_HI:CSC_ECHO_SET_LO];
            assign tone_on_out[g][0] = cfg[g][CSC_REG_TONE][CSC_TONE1_ON_BIT];
            assign tone_on_out[g][1] = cfg[g][CSC_REG_TONE][CSC_TONE2_ON_BIT]
                                       & ~cfg[g][CSC_REG_CUTOFF][CSC_METER_EN_BIT];
            assign tone_custom_out[g] = {cfg[g][CSC_REG_TONE][CSC_TONE2_CUSTOM_BIT],
                                         cfg[g][CSC_REG_TONE][CSC_TONE1_CUSTOM_BIT]};
            assign mu_law_out[g] = cfg[g][CSC_REG_TONE][CSC_MU_LAW_BIT];
            assign power_on_out[g] = cfg[g][CSC_REG_TONE][CSC_POWER_ON_BIT];
            assign cutoff_out[g] = cfg[g][CSC_REG_CUTOFF][CSC_CUTOFF_HI:CSC_CUTOFF_LO];
            assign clear_ram_out[g] = cfg[g][CSC_REG_CUTOFF][CSC_CLEAR_RAM_BIT];
            assign meter_en_out[g] = cfg[g][CSC_REG_CUTOFF][CSC_METER_EN_BIT];
            assign meter_result_out[g] = meter_result[g];
            assign voice_tone_out[g] = cfg[g][CSC_REG_CUTOFF][CSC_VOICE_TONE_BIT];
            assign loopback_out[g] = cfg[g][CSC_REG_LOOP][CSC_LOOP_HI:CSC_LOOP_LO];
            assign tx_boost_out[g] = cfg[g][CSC_REG_LOOP][CSC_TX_BOOST_BIT];
            assign rx_cut_out[g] = cfg[g][CSC_REG_LOOP][CSC_RX_CUT_BIT];
            assign hp_off_out[g] = {cfg[g][CSC_REG_LOOP][CSC_TX_HP_OFF_BIT],
                                    cfg[g][CSC_REG_LOOP][CSC_RX_HP_OFF_BIT]};
        end
    endgenerate
endmodule

// ### core/csc_host.sv
// controller end: register-driven byte engine for the serial command link
`timescale 1ns/1ps
module csc_host
    import csc_pkg::*;
(
    input wire logic clock_in, // 100 MHz clock
    input wire logic rst_n_in, // synchronous reset, active low
    csc_link_if.host link, // serial command link
    input wire logic [7:0] addr_in, // register byte offset
    input wire logic [31:0] wdata_in, // write data
    input wire logic wr_in, // write strobe
    input wire logic rd_in, // read strobe
    output logic [31:0] rdata_out // read data, cycle after rd_in
);
    logic frame;
    logic busy;
    logic refused;
    logic dclk;
    logic din;
    logic [3:0] half_cnt;
    logic [2:0] bit_cnt;
    logic [7:0] tx_shift;
    logic [7:0] rx_shift;
    logic [7:0] rx_data;

    wire start_cmd = wr_in && addr_in == CSC_OFF_TXCMD && frame && !busy;
    wire start_data = wr_in && addr_in == CSC_OFF_TXDATA && frame && !busy;
    wire bad_len = wdata_in[CSC_CMD_KIND_HI:CSC_CMD_KIND_LO] == CSC_KIND_STATUS
                   && wdata_in[CSC_CMD_LEN_HI:CSC_CMD_LEN_LO] > CSC_LEN_MAX;
    wire start = start_data || (start_cmd && !bad_len);
    wire half_done = busy && half_cnt == CSC_HALF_LAST;

    assign link.cs_n = ~frame;
    assign link.dclk = dclk;
    assign link.din = din;

    // deselect may end a frame early
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            frame <= 1'b0;
        end else if (wr_in && addr_in == CSC_OFF_CTRL) begin
            frame <= wdata_in[CSC_CTRL_FRAME_BIT];
        end
    end

    // sticky until the next control write; a refusal in that cycle wins
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            refused <= 1'b0;
        end else if (start_cmd && bad_len) begin
            refused <= 1'b1;
        end else if (wr_in && addr_in == CSC_OFF_CTRL) begin
            refused <= 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in || !frame) begin
            busy <= 1'b0;
            dclk <= 1'b0;
            din <= 1'b1;
            half_cnt <= 4'h0;
            bit_cnt <= 3'h0;
            tx_shift <= CSC_IDLE_BYTE;
            rx_shift <= 8'h00;
        end else if (start) begin
            busy <= 1'b1;
            half_cnt <= 4'h0;
            bit_cnt <= 3'h0;
            tx_shift <= wdata_in[7:0];
            din <= wdata_in[7];
        end else if (half_done) begin
            half_cnt <= 4'h0;
            dclk <= ~dclk;
            if (!dclk) begin
                rx_shift <= {rx_shift[6:0], link.dout};
            end else if (bit_cnt == 3'h7) begin
                busy <= 1'b0;
            end else begin
                bit_cnt <= bit_cnt + 3'h1;
                tx_shift <= {tx_shift[6:0], 1'b1};
                din <= tx_shift[6];
            end
        end else if (busy) begin
            half_cnt <= half_cnt + 4'h1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            rx_data <= 8'h00;
        end else if (half_done && dclk && bit_cnt == 3'h7) begin
            rx_data <= rx_shift;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            rdata_out <= 32'h0;
        end else if (rd_in) begin
            case (addr_in)
                CSC_OFF_CTRL: rdata_out <= {31'h0, frame};
                CSC_OFF_STATUS: rdata_out <= {29'h0, refused, frame, busy};
                CSC_OFF_RXDATA: rdata_out <= {24'h0, rx_data};
                default: rdata_out <= 32'h0;
            endcase
        end else begin
            rdata_out <= 32'h0;
        end
    end
endmodule

// ### test/csc_link_assertions.sv
// timing and framing checks on the serial command link
`timescale 1ns/1ps
module csc_link_assertions (
    input wire logic clock_in, // system clock
    input wire logic rst_n_in, // synchronous reset, active low
    input wire logic cs_n, // chip select, active low
    input wire logic dclk, // bit clock
    input wire logic din, // host to device data
    input wire logic dout // device to host data
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);

    logic [7:0] rises;
    logic dclk_q;

    // rising bit clock edges since select, so a frame can be seen to end on a byte boundary
    always_ff @(posedge clock_in) begin
        dclk_q <= dclk;
        if (!rst_n_in || cs_n) begin
            rises <= 8'h00;
        end else if (dclk && !dclk_q) begin
            rises <= rises + 8'h01;
        end
    end

    sequence s_high_half;
        dclk [*5] ##1 !dclk;
    endsequence

    sequence s_low_half;
        !dclk [*5];
    endsequence

    a_dclk_idle_low: assert property (cs_n |-> !dclk)
        else $error("bit clock not low while deselected");
    a_dout_idle_one: assert property (cs_n && $past(cs_n) && $past(cs_n, 2) |-> dout)
        else $error("device data not idle while deselected");
    a_high_half_len: assert property ($rose(dclk) |-> s_high_half)
        else $error("bit clock high phase has wrong length");
    a_low_half_len: assert property ($fell(dclk) |-> s_low_half)
        else $error("bit clock low phase too short");
    a_din_held_high: assert property (dclk && $past(dclk) |-> $stable(din))
        else $error("host data moved while bit clock high");
    a_dout_held_high: assert property (dclk && $past(dclk) && !cs_n |-> $stable(dout))
        else $error("device data moved while bit clock high");
    a_whole_bytes: assert property ($rose(cs_n) |-> rises[2:0] == 3'h0)
        else $error("frame ended inside a byte");
    a_select_setup: assert property ($fell(cs_n) |-> !dclk [*2])
        else $error("bit clock rose right at select");
    c_frame_seen: cover property ($rose(cs_n));
endmodule

// ### test/tb_codec_status_command_config.sv
// self-checking bench: host and device ends joined over the serial link
`timescale 1ns/1ps
module tb_codec_status_command_config
    import csc_pkg::*;
;
    localparam logic [3:0] loop_codes [10] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9,
        4'hc, 4'hd, 4'hf};
    localparam logic [2:0] cut_codes [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [3:0][CSC_METER_W-1:0] smp = '0;
    logic [3:0] smp_v = 4'h0;
    logic [CSC_METER_W-1:0] thr = 16'h1000;
    logic [3:0][5:0] flt;
    logic [3:0][1:0] eset, ton, tcus, hpo;
    logic [3:0] mu, pwr, clr, men, mres, vt, txb, rxc;
    logic [3:0][2:0] cot;
    logic [3:0][3:0] lpb;
    logic [7:0] cfg [4][4];
    logic [3:0] res_exp = 4'h0;
    logic [7:0] rx;
    int n_fail = 0;
    int cmp_count = 0;

    csc_link_if link ();
    csc_host u_csc_host (.clock_in(clock_in), .rst_n_in(rst_n_in), .link(link), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata));
    csc_device u_csc_device (.clock_in(clock_in), .rst_n_in(rst_n_in), .link(link),
        .meter_sample_in(smp), .meter_valid_in(smp_v), .meter_threshold_in(thr),
        .filter_en_out(flt), .echo_set_out(eset), .tone_on_out(ton), .tone_custom_out(tcus),
        .mu_law_out(mu), .power_on_out(pwr), .cutoff_out(cot), .clear_ram_out(clr),
        .meter_en_out(men), .meter_result_out(mres), .voice_tone_out(vt),
        .loopback_out(lpb), .tx_boost_out(txb), .rx_cut_out(rxc), .hp_off_out(hpo));
    csc_link_assertions u_csc_link_assertions (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .cs_n(link.cs_n), .dclk(link.dclk), .din(link.din), .dout(link.dout));

    always #5 clock_in = ~clock_in;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic print_verdict();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock_in);
        wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_in);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // one byte each way; busy is already set on the edge that takes the write strobe
    task automatic xfer(input logic [7:0] a, input logic [7:0] b, output logic [7:0] r);
        logic [31:0] s;
        bus_wr(a, {24'h0, b});
        repeat (2) @(posedge clock_in);
        for (int i = 0; i < 100; i++) begin
            bus_rd(CSC_OFF_STATUS, s);
            if (s[CSC_STAT_BUSY_BIT] === 1'b0) break;
        end
        if (s[CSC_STAT_BUSY_BIT] !== 1'b0) begin
            chk("busy timeout", 32'h0, {31'h0, s[CSC_STAT_BUSY_BIT]});
            print_verdict();
        end
        bus_rd(CSC_OFF_RXDATA, s);
        r = s[7:0];
    endtask

    function automatic logic [7:0] exp_reg(input int ch, input int i);
        if (i > 3) return 8'h00;
        if (i == 2) return {cfg[ch][2][7:2], res_exp[ch], cfg[ch][2][0]};
        return cfg[ch][i];
    endfunction

    task automatic wr_regs(input int ch, input int len);
        xfer(CSC_OFF_TXCMD, {2'(ch), 1'b0, CSC_KIND_STATUS, 3'(len)}, rx);
        for (int i = len; i >= 0; i--) begin
            xfer(CSC_OFF_TXDATA, cfg[ch][i], rx);
        end
    endtask

    task automatic rd_regs(input int ch, input int len);
        xfer(CSC_OFF_TXCMD, {2'(ch), 1'b1, CSC_KIND_STATUS, 3'(len)}, rx);
        chk("idle byte", CSC_IDLE_BYTE, rx);
        xfer(CSC_OFF_TXDATA, CSC_IDLE_BYTE, rx);
        chk("ident byte", CSC_ID_DEFAULT, rx);
        for (int i = len; i >= 0; i--) begin
            xfer(CSC_OFF_TXDATA, CSC_IDLE_BYTE, rx);
            chk("read byte", exp_reg(ch, i), rx);
        end
    endtask

    task automatic chk_ch(input int ch);
        logic [7:0] r2;
        r2 = cfg[ch][2];
        chk("chan outs", {cfg[ch][0], cfg[ch][1][7] & ~r2[2], cfg[ch][1][6:2], r2[7:5],
            r2[3:2], r2[0], cfg[ch][3]}, {flt[ch], eset[ch], ton[ch], tcus[ch], mu[ch], pwr[ch],
            cot[ch], clr[ch], men[ch], vt[ch], lpb[ch], txb[ch], rxc[ch], hpo[ch]});
        chk("meter result", res_exp[ch], mres[ch]);
    endtask

    initial begin
        logic [31:0] s;
        repeat (10) @(posedge clock_in);
        rst_n_in <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            for (int i = 0; i < 4; i++) begin
                cfg[c][i] = 8'h00;
            end
            chk_ch(c);
        end
        chk("idle lines", 3'b101, {link.cs_n, link.dclk, link.dout});
        bus_rd(8'h14, s);
        chk("unmapped read", 32'h0, s);
        // every channel written, extended and coefficient commands, then all read back in one frame
        bus_wr(CSC_OFF_CTRL, 32'h1);
        bus_rd(CSC_OFF_CTRL, s);
        chk("ctrl readback", 32'h1, s);
        for (int c = 0; c < 4; c++) begin
            cfg[c][0] = 8'h9e ^ 8'(c << 4);
            cfg[c][1] = 8'hb4 ^ 8'(c << 4);
            cfg[c][2] = 8'hc1 ^ 8'(c << 3);
            cfg[c][3] = 8'h06 ^ 8'(c << 6);
            wr_regs(c, 3);
        end
        xfer(CSC_OFF_TXCMD, 8'h19, rx);
        xfer(CSC_OFF_TXDATA, 8'h00, rx);
        xfer(CSC_OFF_TXDATA, 8'h00, rx);
        // long then short coefficient write; a wrong byte count would upset the next decode
        for (int j = 0; j < 2; j++) begin
            xfer(CSC_OFF_TXCMD, 8'h40 | 8'(8 * j), rx);
            for (int i = 0; i < 8 - 4 * j; i++) begin
                xfer(CSC_OFF_TXDATA, 8'hc3, rx);
            end
        end
        xfer(CSC_OFF_TXCMD, 8'h38, rx);
        chk("ext idle", CSC_IDLE_BYTE, rx);
        xfer(CSC_OFF_TXDATA, CSC_IDLE_BYTE, rx);
        chk("ext ident", CSC_ID_DEFAULT, rx);
        xfer(CSC_OFF_TXDATA, CSC_IDLE_BYTE, rx);
        chk("ext data", 32'h0, rx);
        for (int c = 0; c < 4; c++) begin
            rd_regs(c, 3);
        end
        bus_wr(CSC_OFF_CTRL, 32'h0);
        for (int c = 0; c < 4; c++) begin
            chk_ch(c);
        end
        bus_wr(CSC_OFF_CTRL, 32'h1);
        for (int k = 0; k < 10; k++) begin
            cfg[3][3] = {loop_codes[k], 4'h5};
            cfg[3][2] = {cut_codes[k % 5], 5'h09};
            wr_regs(3, 3);
            chk_ch(3);
        end
        for (int l = 0; l <= 5; l++) begin
            rd_regs(3, l);
        end
        // metering blocks tone two; the result bit ignores the attempted write
        cfg[0][2] = 8'h06;
        wr_regs(0, 2);
        chk_ch(0);
        for (int k = 0; k < 2; k++) begin
            @(posedge clock_in);
            // above threshold first, so the later read sees 0 against a stored 1
            smp[0] <= 16'hefff + 16'(k);
            smp_v <= 4'h1;
            @(posedge clock_in);
            smp_v <= 4'h0;
            repeat (2) @(posedge clock_in);
            res_exp[0] = 1'(1 - k);
            #1;
            chk("meter level", res_exp, mres);
        end
        rd_regs(0, 2);
        cfg[0][2] = 8'h01;
        wr_regs(0, 2);
        chk_ch(0);
        // six-byte write cut short after the third byte
        xfer(CSC_OFF_TXCMD, 8'h95, rx);
        xfer(CSC_OFF_TXDATA, 8'h77, rx);
        xfer(CSC_OFF_TXDATA, 8'h77, rx);
        cfg[2][3] = 8'h3a;
        xfer(CSC_OFF_TXDATA, cfg[2][3], rx);
        bus_wr(CSC_OFF_CTRL, 32'h0);
        chk_ch(2);
        bus_wr(CSC_OFF_CTRL, 32'h1);
        bus_wr(CSC_OFF_TXCMD, 32'h16);
        repeat (2) @(posedge clock_in);
        bus_rd(CSC_OFF_STATUS, s);
        chk("refused", 32'h6, {29'h0, s[2:0]});
        bus_wr(CSC_OFF_CTRL, 32'h0);
        bus_rd(CSC_OFF_STATUS, s);
        chk("cleared", 32'h0, {29'h0, s[2:0]});
        chk_ch(0);
        print_verdict();
    end
endmodule
